//--- src/txm_defines.vh
// Register map, field positions, codes and reset values of the transmit modulator
`ifndef TXM_DEFINES_VH
`define TXM_DEFINES_VH

// ==========================================================================
// Register byte offsets on the Wishbone bus
// ==========================================================================
`define TXM_ADR_MOD_CFG2     8'h00
`define TXM_ADR_PKT_CTRL1    8'h04
`define TXM_ADR_PA_CFG1      8'h08
`define TXM_ADR_PA_CFG0      8'h0C
`define TXM_ADR_PA_MAX       8'h10
`define TXM_ADR_PA_ZERO      8'h14
`define TXM_ADR_RATE_M       8'h18
`define TXM_ADR_RATE_E       8'h1C
`define TXM_ADR_FDEV         8'h20
`define TXM_ADR_FCENTER      8'h24
`define TXM_ADR_CMD          8'h28
`define TXM_ADR_FIFO_DATA    8'h2C
`define TXM_ADR_STATUS       8'h30
`define TXM_ADR_FIFO_THR     8'h34

// ==========================================================================
// Field positions
// ==========================================================================
`define TXM_MODULATION_TYPE_FIELD_HI      6
`define TXM_MODULATION_TYPE_FIELD_LO      4
`define TXM_SRC_HI           3
`define TXM_SRC_LO           2
`define TXM_OOK_FIR_SMOOTH_ENABLE_BIT       0
`define TXM_FIR_MODE_HI      2
`define TXM_FIR_MODE_LO      1
`define TXM_FC_HI            1
`define TXM_FC_LO            0
`define TXM_DIG_RAMP_BIT     7
`define TXM_SMOOTH_BIT       7
`define TXM_CMD_START_BIT    0
`define TXM_CMD_ABORT_BIT    1

// ==========================================================================
// Codes
// ==========================================================================
`define TXM_MOD_ASK          3'h5
`define TXM_MOD_POLAR        3'h6
`define TXM_MOD_CW           3'h7
`define TXM_SRC_PN9          2'h3
`define TXM_FIR_FILTER       2'h0
`define TXM_FIR_RAMP         2'h1
`define TXM_FIR_SWITCH       2'h2
`define TXM_RATE_E_FREE      4'hF

// ==========================================================================
// Sizes, reset values and constants
// ==========================================================================
`define TXM_FIFO_DEPTH       8'h80
`define TXM_LEVEL_FULL       4'h8
`define TXM_PHASE_LAST       3'h7
`define TXM_PN9_SEED         9'h1FF
`define TXM_RST_MOD_CFG2     8'h00
`define TXM_RST_RATE_M       16'h0000
`define TXM_RST_RATE_E       4'h0
`define TXM_RST_FIFO_THR     7'h30

`endif

//--- src/txm_fifo_mem.v
// Transmit FIFO storage: 128 x 8 memory with registered read data
`default_nettype none

module txm_fifo_mem (
  input  wire       clk_in,
  input  wire       rstn_in,
  input  wire       wr_en_in,
  input  wire [6:0] wr_addr_in,
  input  wire [7:0] wr_data_in,
  input  wire [6:0] rd_addr_in,
  output reg  [7:0] rd_data_out
);

  // ========================================================================
  // Storage
  // ========================================================================
  reg [7:0] mem_q [0:127];   // Byte array, not reset

  // Write port
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_q[wr_addr_in] <= wr_data_in;
    end
  end

  // Read port; a same-edge write returns the old byte
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 8'h00;
    end else begin
      rd_data_out <= mem_q[rd_addr_in];
    end
  end

endmodule

`default_nettype wire

//--- src/txm_modulator.v
// Transmit modulator: OOK smoothing, direct polar, CW, PN9 and data-rate generator
//
// Function
// - FIR enable inserts smoothing stage in OOK path
// - Three FIR modes; filter averages eight samples
// - Ramp mode ramps between maximum and zero level
// - Switch mode maps bits straight to levels
// - FIR ramp and digital ramp never combine
// - Polar pairs fetched at eight times rate
// - Deviation is programmed deviation times byte/128
// - Polar frequency is centre plus deviation
// - Second polar byte sets PA power
// - Polar transmission ends only on abort
// - Modulation code 7 sends carrier until abort
// - Source code 3 sends PN9 until abort
// - Rate follows exponent and mantissa formulas
// - Exponent 15 jitter-free divider, others fractional
// - Rate span 0.1 to 500 kbps
// - Modulation code selects polar or carrier
// - ASK: one at maximum, zero at level zero
`default_nettype none
`include "txm_defines.vh"

module txm_modulator (
  input  wire        clk_in,
  input  wire        rstn_in,
  input  wire        wb_cyc_in,
  input  wire        wb_stb_in,
  input  wire        wb_we_in,
  input  wire [7:0]  wb_adr_in,
  input  wire [31:0] wb_dat_in,
  input  wire [3:0]  wb_sel_in,
  output reg  [31:0] wb_dat_out,
  output reg         wb_ack_out,
  output reg  [31:0] frequency_synthesizer_freq_out,
  output reg  [6:0]  pa_power_out,
  output reg         pa_enable_out,
  output wire [1:0]  bessel_cutoff_out,
  output reg         tx_active_out,
  output wire        fifo_thresh_out
);

  // ========================================================================
  // State codes
  // ========================================================================
  localparam ST_IDLE  = 2'h0;   // No transmission
  localparam ST_RUN   = 2'h1;   // Transmitting
  localparam ST_POP1  = 2'h2;   // Polar: wait for second byte
  localparam ST_POP2  = 2'h3;   // Polar: take second byte

  // ========================================================================
  // Functions
  // ========================================================================
  // Byte-lane merge of a write into a register image
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      i;
    begin
      lane_merge = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          lane_merge[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Level between zero and maximum in eighths
  function [6:0] level_mix;
    input [6:0] lo;
    input [6:0] hi;
    input [3:0] k;
    reg signed [8:0]  diff;
    reg signed [13:0] prod;
    reg signed [13:0] tot;
    begin
      diff      = $signed({2'h0, hi}) - $signed({2'h0, lo});
      prod      = diff * $signed({1'b0, k});
      tot       = $signed({7'h00, lo}) + (prod >>> 3);
      level_mix = tot[6:0];
    end
  endfunction

  // ========================================================================
  // Registers
  // ========================================================================
  reg  [7:0]  mod_cfg2_q;     // modulation_config_two
  reg  [7:0]  pkt_ctrl1_q;    // packet_control_one
  reg  [7:0]  pa_cfg1_q;      // pa_config_one
  reg  [7:0]  pa_cfg0_q;      // pa_config_zero
  reg  [6:0]  pa_max_q;       // pa_level_maximum
  reg  [7:0]  pa_zero_q;      // pa_level_zero plus smoothing bit
  reg  [15:0] rate_m_q;       // rate_mantissa
  reg  [3:0]  rate_e_q;       // rate_exponent
  reg  [15:0] fdev_q;         // Programmed deviation
  reg  [31:0] fcenter_q;      // Channel centre frequency word
  reg  [6:0]  fifo_thr_q;     // FIFO threshold

  // Transmit state
  reg  [1:0]  state_q;
  reg  [35:0] acc_q;          // Fractional divider phase
  reg  [15:0] div_q;          // Integer divider count
  reg  [2:0]  phase_q;        // Sample index within a bit
  reg  [8:0]  pn9_q;          // PN9 generator
  reg  [7:0]  shift_q;        // Bits of current FIFO byte
  reg  [2:0]  bits_left_q;    // Bits still in shift_q
  reg         cur_bit_q;      // Bit on air
  reg  [7:0]  hist_q;         // Oversampled bit history
  reg  [3:0]  ramp_q;         // Ramp position in eighths
  reg  [7:0]  dev_byte_q;     // First byte of polar pair
  reg  [6:0]  rd_ptr_q;
  reg  [6:0]  wr_ptr_q;
  reg  [7:0]  count_q;        // FIFO fill, 0..128

  wire [7:0]  rd_byte;
  wire [2:0]  modulation_type_field  = mod_cfg2_q[`TXM_MODULATION_TYPE_FIELD_HI:`TXM_MODULATION_TYPE_FIELD_LO];
  wire [1:0]  tx_src    = pkt_ctrl1_q[`TXM_SRC_HI:`TXM_SRC_LO];
  wire        ook_fir_smooth_enable    = pa_cfg1_q[`TXM_OOK_FIR_SMOOTH_ENABLE_BIT];
  wire [1:0]  fir_mode  = pa_cfg1_q[`TXM_FIR_MODE_HI:`TXM_FIR_MODE_LO];
  wire        dig_ramp  = pa_cfg0_q[`TXM_DIG_RAMP_BIT];
  wire        is_polar  = (modulation_type_field == `TXM_MOD_POLAR);
  wire        is_cw     = (modulation_type_field == `TXM_MOD_CW);
  wire        is_ask    = (modulation_type_field == `TXM_MOD_ASK);
  wire        use_pn9   = (tx_src == `TXM_SRC_PN9);

  // ========================================================================
  // Wishbone slave
  // ========================================================================
  wire        wb_req    = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire        wb_wr     = wb_req && wb_we_in;
  wire        cmd_wr    = wb_wr && (wb_adr_in == `TXM_ADR_CMD) && wb_sel_in[0];
  wire        start_cmd = cmd_wr && wb_dat_in[`TXM_CMD_START_BIT];
  wire        abort_cmd = cmd_wr && wb_dat_in[`TXM_CMD_ABORT_BIT];
  wire        push      = wb_wr && (wb_adr_in == `TXM_ADR_FIFO_DATA) && wb_sel_in[0]
                          && (count_q != `TXM_FIFO_DEPTH);
  // Wide registers merge per lane, then keep only their own bits
  wire [31:0] rate_m_mrg = lane_merge({16'h0000, rate_m_q}, wb_dat_in, wb_sel_in);
  wire [31:0] fdev_mrg   = lane_merge({16'h0000, fdev_q}, wb_dat_in, wb_sel_in);

  // Register writes and one-cycle ack
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_ack_out  <= 1'b0;
      mod_cfg2_q  <= `TXM_RST_MOD_CFG2;
      pkt_ctrl1_q <= 8'h00;
      pa_cfg1_q   <= 8'h00;
      pa_cfg0_q   <= 8'h00;
      pa_max_q    <= 7'h00;
      pa_zero_q   <= 8'h00;
      rate_m_q    <= `TXM_RST_RATE_M;
      rate_e_q    <= `TXM_RST_RATE_E;
      fdev_q      <= 16'h0000;
      fcenter_q   <= 32'h0000_0000;
      fifo_thr_q  <= `TXM_RST_FIFO_THR;
    end else begin
      wb_ack_out <= wb_req;
      if (wb_wr) begin
        // Byte registers need lane 0; wide ones merge per lane
        case (wb_adr_in)
          `TXM_ADR_MOD_CFG2:  if (wb_sel_in[0]) mod_cfg2_q  <= wb_dat_in[7:0];
          `TXM_ADR_PKT_CTRL1: if (wb_sel_in[0]) pkt_ctrl1_q <= wb_dat_in[7:0];
          `TXM_ADR_PA_CFG1:   if (wb_sel_in[0]) pa_cfg1_q   <= wb_dat_in[7:0];
          `TXM_ADR_PA_CFG0:   if (wb_sel_in[0]) pa_cfg0_q   <= wb_dat_in[7:0];
          `TXM_ADR_PA_MAX:    if (wb_sel_in[0]) pa_max_q    <= wb_dat_in[6:0];
          `TXM_ADR_PA_ZERO:   if (wb_sel_in[0]) pa_zero_q   <= wb_dat_in[7:0];
          `TXM_ADR_RATE_M:    rate_m_q  <= rate_m_mrg[15:0];
          `TXM_ADR_RATE_E:    if (wb_sel_in[0]) rate_e_q    <= wb_dat_in[3:0];
          `TXM_ADR_FDEV:      fdev_q    <= fdev_mrg[15:0];
          `TXM_ADR_FCENTER:   fcenter_q <= lane_merge(fcenter_q, wb_dat_in, wb_sel_in);
          `TXM_ADR_FIFO_THR:  if (wb_sel_in[0]) fifo_thr_q  <= wb_dat_in[6:0];
          default:            fcenter_q <= fcenter_q;
        endcase
      end
    end
  end

  // Read data, registered with the ack; unmapped reads give zero
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_req) begin
      case (wb_adr_in)
        `TXM_ADR_MOD_CFG2:  wb_dat_out <= {24'h00_0000, mod_cfg2_q};
        `TXM_ADR_PKT_CTRL1: wb_dat_out <= {24'h00_0000, pkt_ctrl1_q};
        `TXM_ADR_PA_CFG1:   wb_dat_out <= {24'h00_0000, pa_cfg1_q};
        `TXM_ADR_PA_CFG0:   wb_dat_out <= {24'h00_0000, pa_cfg0_q};
        `TXM_ADR_PA_MAX:    wb_dat_out <= {25'h000_0000, pa_max_q};
        `TXM_ADR_PA_ZERO:   wb_dat_out <= {24'h00_0000, pa_zero_q};
        `TXM_ADR_RATE_M:    wb_dat_out <= {16'h0000, rate_m_q};
        `TXM_ADR_RATE_E:    wb_dat_out <= {28'h000_0000, rate_e_q};
        `TXM_ADR_FDEV:      wb_dat_out <= {16'h0000, fdev_q};
        `TXM_ADR_FCENTER:   wb_dat_out <= fcenter_q;
        `TXM_ADR_STATUS:    wb_dat_out <= {16'h0000, count_q, 6'h00, fifo_thresh_out, tx_active_out};
        `TXM_ADR_FIFO_THR:  wb_dat_out <= {25'h000_0000, fifo_thr_q};
        default:            wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  // Lane merge result unused bits would be dropped silently otherwise
  wire unused_merge = |{rate_m_mrg[31:16], fdev_mrg[31:16]};

  assign bessel_cutoff_out = pa_cfg0_q[`TXM_FC_HI:`TXM_FC_LO];
  assign fifo_thresh_out   = (count_q <= {1'b0, fifo_thr_q});

  // ========================================================================
  // Data-rate generator: one tick per sample, eight samples a bit
  // ========================================================================
  wire [4:0]  shamt     = {1'b0, rate_e_q} + 5'h02;
  wire [35:0] rate_inc  = (rate_e_q == 4'h0) ? {17'h0_0000, rate_m_q, 3'h0} :
                          ({19'h0_0000, 1'b1, rate_m_q} << shamt);
  wire [35:0] acc_sum   = {4'h0, acc_q[31:0]} + rate_inc;
  wire        free_mode = (rate_e_q == `TXM_RATE_E_FREE);
  // Exponent 15 divides by the mantissa exactly, other exponents dither
  wire        samp_tick = (state_q != ST_IDLE) &&
                          (free_mode ? (div_q == 16'h0000) : (|acc_sum[35:32]));
  wire        bit_tick  = samp_tick && (phase_q == `TXM_PHASE_LAST);

  // Divider state; restarts from zero phase each transmission
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_q   <= 36'h0_0000_0000;
      div_q   <= 16'h0000;
      phase_q <= 3'h0;
    end else if (state_q == ST_IDLE) begin
      acc_q   <= 36'h0_0000_0000;
      div_q   <= 16'h0000;
      phase_q <= 3'h0;
    end else begin
      acc_q <= {4'h0, acc_sum[31:0]};
      // Mantissa 0 behaves as 1 in the integer divider
      if (div_q == 16'h0000) begin
        div_q <= (rate_m_q == 16'h0000) ? 16'h0000 : rate_m_q - 16'h0001;
      end else begin
        div_q <= div_q - 16'h0001;
      end
      if (samp_tick) begin
        phase_q <= phase_q + 3'h1;
      end
    end
  end

  // ========================================================================
  // Transmit FIFO
  // ========================================================================
  wire polar_pop0 = (state_q == ST_RUN) && is_polar && samp_tick && (count_q >= 8'h02);
  wire polar_pop1 = (state_q == ST_POP2);
  wire bit_pop    = (state_q == ST_RUN) && !is_polar && !is_cw && !use_pn9 && bit_tick &&
                    (bits_left_q == 3'h0) && (count_q != 8'h00);
  wire pop        = polar_pop0 || polar_pop1 || bit_pop;

  txm_fifo_mem u_mem (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (push),
    .wr_addr_in  (wr_ptr_q),
    .wr_data_in  (wb_dat_in[7:0]),
    .rd_addr_in  (rd_ptr_q),
    .rd_data_out (rd_byte)
  );

  // Pointers and fill level
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_ptr_q <= 7'h00;
      wr_ptr_q <= 7'h00;
      count_q  <= 8'h00;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 7'h01;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 7'h01;
      end
      case ({push, pop})
        2'b10:   count_q <= count_q + 8'h01;
        2'b01:   count_q <= count_q - 8'h01;
        default: count_q <= count_q;
      endcase
    end
  end

  // ========================================================================
  // Bit source: PN9 or FIFO bytes, MSB first
  // ========================================================================
  wire fifo_done = !use_pn9 && !is_polar && !is_cw && bit_tick &&
                   (bits_left_q == 3'h0) && (count_q == 8'h00);

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pn9_q       <= `TXM_PN9_SEED;
      shift_q     <= 8'h00;
      bits_left_q <= 3'h0;
      cur_bit_q   <= 1'b0;
    end else if (state_q == ST_IDLE) begin
      pn9_q       <= `TXM_PN9_SEED;
      bits_left_q <= 3'h0;
      cur_bit_q   <= 1'b0;
    end else if (bit_tick) begin
      if (use_pn9) begin
        // x^9 + x^5 + 1, runs until abort
        cur_bit_q <= pn9_q[0];
        pn9_q     <= {pn9_q[0] ^ pn9_q[4], pn9_q[8:1]};
      end else if (bit_pop) begin
        cur_bit_q   <= rd_byte[7];
        shift_q     <= {rd_byte[6:0], 1'b0};
        bits_left_q <= 3'h7;
      end else if (bits_left_q != 3'h0) begin
        cur_bit_q   <= shift_q[7];
        shift_q     <= {shift_q[6:0], 1'b0};
        bits_left_q <= bits_left_q - 3'h1;
      end
    end
  end

  // ========================================================================
  // Amplitude shaping
  // ========================================================================
  reg [3:0] hist_ones;
  reg [3:0] shape_k;
  integer   j;
  wire      ramp_path = ook_fir_smooth_enable ? (fir_mode == `TXM_FIR_RAMP) : dig_ramp;

  // Ones count over the last eight samples
  always @* begin
    hist_ones = 4'h0;
    for (j = 0; j < 8; j = j + 1) begin
      hist_ones = hist_ones + {3'h0, hist_q[j]};
    end
  end

  // Eighths of the way from level zero to maximum
  always @* begin
    shape_k = cur_bit_q ? `TXM_LEVEL_FULL : 4'h0;
    if (ook_fir_smooth_enable && (fir_mode == `TXM_FIR_FILTER)) begin
      shape_k = hist_ones;
    end else if (ramp_path) begin
      shape_k = ramp_q;
    end else if (ook_fir_smooth_enable && (fir_mode == `TXM_FIR_SWITCH)) begin
      shape_k = cur_bit_q ? `TXM_LEVEL_FULL : 4'h0;
    end
  end

  // History and ramp advance once per sample
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hist_q <= 8'h00;
      ramp_q <= 4'h0;
    end else if (state_q == ST_IDLE) begin
      hist_q <= 8'h00;
      ramp_q <= 4'h0;
    end else if (samp_tick) begin
      hist_q <= {hist_q[6:0], cur_bit_q};
      if (cur_bit_q && (ramp_q != `TXM_LEVEL_FULL)) begin
        ramp_q <= ramp_q + 4'h1;
      end else if (!cur_bit_q && (ramp_q != 4'h0)) begin
        ramp_q <= ramp_q - 4'h1;
      end
    end
  end

  // ========================================================================
  // Polar deviation
  // ========================================================================
  wire signed [24:0] dev_prod = $signed({1'b0, fdev_q}) * $signed(dev_byte_q);
  wire signed [24:0] dev_div  = dev_prod >>> 7;
  wire        [31:0] polar_f  = fcenter_q + {{7{dev_div[24]}}, dev_div};

  // ========================================================================
  // Sequencer and outputs
  // ========================================================================
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q        <= ST_IDLE;
      dev_byte_q     <= 8'h00;
      frequency_synthesizer_freq_out <= 32'h0000_0000;
      pa_power_out   <= 7'h00;
      pa_enable_out  <= 1'b0;
      tx_active_out  <= 1'b0;
    end else if (abort_cmd) begin
      // Abort wins over everything, next cycle all drive stops
      state_q        <= ST_IDLE;
      frequency_synthesizer_freq_out <= fcenter_q;
      pa_power_out   <= 7'h00;
      pa_enable_out  <= 1'b0;
      tx_active_out  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          frequency_synthesizer_freq_out <= fcenter_q;
          pa_power_out   <= 7'h00;
          pa_enable_out  <= 1'b0;
          tx_active_out  <= 1'b0;
          if (start_cmd) begin
            state_q       <= ST_RUN;
            tx_active_out <= 1'b1;
          end
        end
        ST_RUN: begin
          pa_enable_out <= 1'b1;
          if (is_polar) begin
            // Underrun holds the last pair; no automatic end
            if (polar_pop0) begin
              dev_byte_q <= rd_byte;
              state_q    <= ST_POP1;
            end
          end else if (is_cw) begin
            frequency_synthesizer_freq_out <= fcenter_q;
            pa_power_out   <= pa_max_q;
          end else if (fifo_done) begin
            state_q       <= ST_IDLE;
            tx_active_out <= 1'b0;
          end else begin
            frequency_synthesizer_freq_out <= fcenter_q;
            pa_power_out   <= is_ask ? level_mix(pa_zero_q[6:0], pa_max_q, shape_k) : pa_max_q;
          end
        end
        ST_POP1: begin
          state_q <= ST_POP2;
        end
        ST_POP2: begin
          frequency_synthesizer_freq_out <= polar_f;
          pa_power_out   <= rd_byte[6:0];
          state_q        <= ST_RUN;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Rate span 0.1 to 500 kbps is reached through exponent/mantissa at 20 MHz
  wire unused_bits = unused_merge | pa_zero_q[`TXM_SMOOTH_BIT] | acc_q[35];

endmodule

`default_nettype wire

//--- src/unused_marker.v
`default_nettype none
`default_nettype wire

//--- tb/txm_chk.sv
// Checker bound to the transmit modulator ports
`default_nettype none
module txm_chk (
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic        wb_ack_out,
  input wire logic [31:0] frequency_synthesizer_freq_out,
  input wire logic [6:0]  pa_power_out,
  input wire logic [1:0]  bessel_cutoff_out,
  input wire logic        tx_active_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================
  // Shadow copies of mode, source, centre
  wire logic  req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic  wr  = req && wb_we_in;
  wire logic  abt = wr && wb_adr_in == 8'h28 && wb_dat_in[1];
  logic [2:0]  mod_q;
  logic [1:0]  src_q;
  logic [1:0]  ab_q;   // Recent-abort window
  logic [31:0] ctr_q;
  // Track writes as the design should take them
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      {mod_q, src_q, ab_q, ctr_q} <= '0;
    end else begin
      if (wr && wb_adr_in == 8'h00) mod_q <= wb_dat_in[6:4];
      if (wr && wb_adr_in == 8'h04) src_q <= wb_dat_in[3:2];
      if (wr && wb_adr_in == 8'h24) ctr_q <= wb_dat_in;
      ab_q <= abt ? 2'h3 : (ab_q != 2'h0) ? ab_q - 2'h1 : 2'h0;
    end
  end
  // ==========================================
  // Assertions
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack too long");
  AST_ACK_ANSWER: assert property (req |=> wb_ack_out)
    else $error("ack missing");
  AST_UNMAPPED: assert property (req && !wb_we_in && wb_adr_in > 8'h34 |=> wb_dat_out == 32'h0)
    else $error("unmapped read not zero");
  AST_CUTOFF: assert property (wr && wb_adr_in == 8'h0C |=> bessel_cutoff_out == $past(wb_dat_in[1:0]))
    else $error("cutoff not passed");
  AST_TEST_END: assert property ($fell(tx_active_out) && mod_q[2:1] == 2'b11 |-> ab_q != 2'h0)
    else $error("polar or carrier ended alone");
  AST_PN9_END: assert property ($fell(tx_active_out) && src_q == 2'h3 |-> ab_q != 2'h0)
    else $error("pn9 ended alone");
  AST_CW_FREQ: assert property (mod_q == 3'h7 && tx_active_out && $past(tx_active_out, 2) |-> frequency_synthesizer_freq_out == ctr_q)
    else $error("carrier not at centre");
  AST_ABORT: assert property (abt |=> ##[0:1] (!tx_active_out && pa_power_out == 7'h00))
    else $error("abort slow");
  cover property (abt && mod_q == 3'h6);
  cover property ($rose(tx_active_out) && mod_q == 3'h7);
  cover property (tx_active_out && src_q == 2'h3);
endmodule
bind txm_modulator txm_chk u_chk (.*);
`default_nettype wire

//--- tb/txm_host.sv
// Host model: classic Wishbone master feeding the modulator
`default_nettype none
module txm_host (
  input  wire logic        clk_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] dat_in,
  output var  logic        cyc_out,
  output var  logic        stb_out,
  output var  logic        we_out,
  output var  logic [7:0]  adr_out,
  output var  logic [31:0] dat_out,
  output var  logic [3:0]  sel_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {cyc_out, stb_out, we_out, adr_out, dat_out, sel_out} = '0;
  // One cycle, held until ack is sampled or 50 clocks pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic to);
    int n;
    @(posedge clk_in);
    {cyc_out, stb_out, we_out, adr_out, dat_out, sel_out} <= {2'b11, w, a, d, 4'hF};
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack_in !== 1'b1 && n < 50);
    r = dat_in;
    to = ack_in !== 1'b1;
    {cyc_out, stb_out} <= 2'b00;
  endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the transmit modulator
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] CF = 32'h1000_0000;
  logic        clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        cyc, stb, we, ack, pen, act, thr, mid;
  logic [7:0]  adr;
  logic [31:0] dat, rdat, frq, v;
  logic [3:0]  sel;
  logic [6:0]  pa;
  logic [1:0]  bc;
  int          errors = 0;
  int          cmp_count = 0;
  int          cnt;
  initial forever #25 clk_in = ~clk_in;
  txm_host u_txm_host (.clk_in(clk_in), .ack_in(ack), .dat_in(rdat), .cyc_out(cyc), .stb_out(stb),
    .we_out(we), .adr_out(adr), .dat_out(dat), .sel_out(sel));
  txm_modulator u_txm_modulator (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(sel), .wb_dat_out(rdat),
    .wb_ack_out(ack), .frequency_synthesizer_freq_out(frq), .pa_power_out(pa), .pa_enable_out(pen),
    .bessel_cutoff_out(bc), .tx_active_out(act), .fifo_thresh_out(thr));
  // ==========================================
  // Tasks
  task automatic conclude;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic ac(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic to;
    u_txm_host.xfer(w, a, d, v, to);
    if (to) begin
      errors++;
      conclude();
    end
  endtask
  // ==========================================
  // Scenarios
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    ac(0, 8'h30, 0);
    chk("status", v, 32'h0000_0002);
    ac(0, 8'h3C, 0);
    chk("unmapped", v, 32'h0);
    ac(1, 8'h0C, 32'h0000_0003);
    chk("cutoff", {30'h0, bc}, 32'h3);
    ac(1, 8'h24, CF);
    ac(1, 8'h10, 32'h0000_0055);
    ac(1, 8'h14, 32'h0000_0000);
    ac(1, 8'h20, 32'h0000_0100);
    ac(1, 8'h1C, 32'h0000_000F);
    ac(1, 8'h00, 32'h0000_0077);
    ac(1, 8'h28, 32'h0000_0001);
    repeat (200) @(negedge clk_in);
    chk("cw active", {31'h0, act}, 32'h1);
    chk("cw freq", frq, CF);
    chk("cw power", {25'h0, pa}, 32'h55);
    chk("cw pa on", {31'h0, pen}, 32'h1);
    ac(1, 8'h28, 32'h0000_0002);
    repeat (2) @(negedge clk_in);
    chk("abort power", {25'h0, pa}, 32'h0);
    ac(1, 8'h34, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      ac(1, 8'h00, 32'h0000_0060);
      ac(1, 8'h2C, i ? 32'h0000_00C0 : 32'h0000_0040);
      ac(1, 8'h2C, i ? 32'h0000_009A : 32'h0000_0022);
      chk("thr above", {31'h0, thr}, 32'h0);
      ac(1, 8'h28, 32'h0000_0001);
      repeat (40) @(negedge clk_in);
      chk("polar freq", frq, i ? CF - 32'd128 : CF + 32'd128);
      chk("polar power", {25'h0, pa}, i ? 32'h1A : 32'h22);
      chk("polar held", {31'h0, act}, 32'h1);
      chk("thr below", {31'h0, thr}, 32'h1);
      ac(1, 8'h28, 32'h0000_0002);
    end
    ac(1, 8'h00, 32'h0000_0050);
    ac(1, 8'h04, 32'h0000_000C);
    ac(1, 8'h28, 32'h0000_0001);
    repeat (300) @(negedge clk_in);
    chk("pn9 active", {31'h0, act}, 32'h1);
    chk("ask level", {31'h0, pa == 7'h00 || pa == 7'h55}, 32'h1);
    ac(1, 8'h28, 32'h0000_0002);
    repeat (2) @(negedge clk_in);
    chk("pn9 stop", {31'h0, act}, 32'h0);
    // FIFO-fed OOK through filter, ramp and switch; equal rates by both dividers
    ac(1, 8'h04, 32'h0);
    ac(1, 8'h14, 32'h80);
    for (int i = 0; i < 3; i++) begin
      ac(1, 8'h08, i ? (i > 1 ? 32'h5 : 32'h3) : 32'h1);
      ac(1, 8'h0C, i > 1 ? 32'h83 : 32'h3);
      ac(1, 8'h18, i ? 32'h2 : 32'h0);
      ac(1, 8'h1C, i ? 32'hF : 32'hD);
      ac(1, 8'h2C, 32'hF0);
      ac(1, 8'h28, 32'h1);
      mid = 1'b0;
      for (cnt = 0; cnt < 300 && act; cnt++) begin
        @(negedge clk_in);
        if (pa != 7'h00 && pa != 7'h55) mid = 1'b1;
      end
      chk("fir shaping", {31'h0, mid}, {31'h0, i < 2});
      chk("bit time", {31'h0, cnt >= 140 && cnt <= 150}, 32'h1);
      chk("fifo end", {31'h0, act}, 32'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
